// File: core/msc_pkg.sv
package msc_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_SRD = 8'h19;
  localparam logic [7:0] IDX_THR = 8'h1F;
  localparam logic [7:0] IDX_WST = 8'h3A;
  localparam logic [7:0] IDX_MWC = 8'h69;
  localparam logic [7:0] IDX_UCR = 8'h6A;
  localparam logic [7:0] IDX_PC1 = 8'h6B;
  localparam logic [7:0] IDX_APC = 8'h6C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MWC_EN     = 7;
  localparam int MWC_MODE   = 6;
  localparam int UCR_MP_EN  = 7;
  localparam int UCR_FIFO   = 6;
  localparam int UCR_SLV    = 4;
  localparam int UCR_MP_RST = 3;
  localparam int UCR_FF_RST = 2;
  localparam int UCR_PATH   = 0;
  localparam int PC1_DEVRST = 7;
  localparam int PC1_SLEEP  = 6;
  localparam int PC1_CYCLE  = 5;
  localparam int PC1_STBY   = 4;
  localparam int APC_XA     = 5;
  localparam int APC_YA     = 4;
  localparam int APC_ZA     = 3;
  localparam int WST_X      = 7;
  localparam int WST_Y      = 6;
  localparam int WST_Z      = 5;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_MWC  = 8'h00;
  localparam logic [7:0] RST_UCR  = 8'h00;
  localparam logic [7:0] RST_PC1  = 8'h40;
  localparam logic [7:0] RST_APC  = 8'h00;
  localparam logic [7:0] RST_SRD  = 8'h00;
  localparam logic [7:0] RST_THR  = 8'h00;
  localparam logic [7:0] MASK_MWC = 8'hC0;
  localparam logic [7:0] MASK_UCR = 8'hC0;
  localparam logic [7:0] MASK_PC1 = 8'h70;
  localparam logic [7:0] MASK_APC = 8'h3F;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int EIGHT_MHZ_PERIOD_PS = 125000;
  localparam int PATH_RST_CYCLES   = EIGHT_MHZ_PERIOD_PS / CLK_PERIOD_PS;
  localparam int WAKE_BASE_US      = 1000;
  localparam int WAKE_BASE_CYCLES  = (WAKE_BASE_US * 1000000) / CLK_PERIOD_PS;

  // ----------------------------------------
  // Motion processor run states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MSC_MP_OFF,
    MSC_MP_RUN,
    MSC_MP_DRAIN
  } msc_mp_state_t;

endpackage : msc_pkg

// File: core/msc_pulse.sv
`timescale 1ns/10ps
`default_nettype none

module msc_pulse #(
  parameter int LEN = 31
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Trigger and pulse
  input  wire logic start_i,
  output var  logic pulse_o
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_q;

  // A retrigger while the pulse runs restarts the full length.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      pulse_o <= 1'b0;
    end else if (start_i) begin
      cnt_q   <= CW'(LEN - 1);
      pulse_o <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q   <= cnt_q - CW'(1);
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule : msc_pulse

`default_nettype wire

// File: core/msc_regs.sv
`timescale 1ns/10ps
`default_nettype none

module msc_regs #(
  parameter int AW               = 10,
  parameter int WAKE_BASE_CYCLES = msc_pkg::WAKE_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [AW-1:0]     wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  // Accelerometer samples
  input  wire logic              accel_valid_i,
  input  wire logic [15:0]       accel_x_i,
  input  wire logic [15:0]       accel_y_i,
  input  wire logic [15:0]       accel_z_i,
  // Motion processor
  input  wire logic              mp_done_i,
  input  wire logic              rate_8khz_i,
  output var  logic              mp_run_o,
  output var  logic              mp_reset_o,
  // FIFO and serial slave
  output var  logic              fifo_host_access_o,
  output var  logic              fifo_reset_o,
  output var  logic              slave_reset_o,
  // Sensor paths and power
  output var  logic              path_reset_o,
  output var  logic              device_reset_o,
  output var  logic              sleep_o,
  output var  logic              gyro_drive_en_o,
  output var  logic              pll_en_o,
  output var  logic              gyro_sense_en_o,
  output var  logic              accel_wake_o,
  output var  logic              accel_sample_o,
  output var  logic [2:0]        wake_flags_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [16:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    abs_diff = d[16] ? 17'(-d) : 17'(d);
  endfunction : abs_diff

  function automatic logic hit(input logic [16:0] diff, input logic [7:0] thr);
    hit = diff > {9'h000, thr};
  endfunction : hit

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  wdat;
  logic        srst;

  logic [7:0]  mwc_q;
  logic [7:0]  ucr_q;
  logic [7:0]  pc1_q;
  logic [7:0]  apc_q;
  logic [7:0]  srd_q;
  logic [7:0]  thr_q;
  logic [7:0]  wst_q;
  logic        slv_q;
  logic        mprst_q;
  logic        ffrst_q;
  logic        devrst_q;
  logic        path_start;

  assign idx  = wb_adr_i[AW-1:2];
  assign req  = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where ack is seen, matching the master.
  assign wr   = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign rd   = req & ~wb_we_i & wb_ack_o;
  assign wdat = wb_dat_i[7:0];
  assign srst = rst_i | devrst_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      case (idx)
        msc_pkg::IDX_MWC: wb_dat_o <= {24'h000000, mwc_q & msc_pkg::MASK_MWC};
        msc_pkg::IDX_UCR: wb_dat_o <= {24'h000000, ucr_q[7:6], 1'b0, slv_q, mprst_q, ffrst_q, 1'b0,
                                       path_start | path_reset_o};
        msc_pkg::IDX_PC1: wb_dat_o <= {24'h000000, devrst_q, pc1_q[6:4], 4'h0};
        msc_pkg::IDX_APC: wb_dat_o <= {24'h000000, apc_q};
        msc_pkg::IDX_SRD: wb_dat_o <= {24'h000000, srd_q};
        msc_pkg::IDX_THR: wb_dat_o <= {24'h000000, thr_q};
        msc_pkg::IDX_WST: wb_dat_o <= {24'h000000, wst_q};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Stored control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst) begin
      mwc_q <= msc_pkg::RST_MWC;
      ucr_q <= msc_pkg::RST_UCR;
      pc1_q <= msc_pkg::RST_PC1;
      apc_q <= msc_pkg::RST_APC;
      srd_q <= msc_pkg::RST_SRD;
      thr_q <= msc_pkg::RST_THR;
    end else if (wr) begin
      case (idx)
        msc_pkg::IDX_MWC: mwc_q <= wdat & msc_pkg::MASK_MWC;
        msc_pkg::IDX_UCR: ucr_q <= wdat & msc_pkg::MASK_UCR;
        msc_pkg::IDX_PC1: pc1_q <= wdat & msc_pkg::MASK_PC1;
        msc_pkg::IDX_APC: apc_q <= wdat & msc_pkg::MASK_APC;
        msc_pkg::IDX_SRD: srd_q <= wdat;
        msc_pkg::IDX_THR: thr_q <= wdat;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Self-clearing strobes
  // ----------------------------------------
  logic wr_ucr;
  logic wr_pc1;

  assign wr_ucr     = wr & (idx == msc_pkg::IDX_UCR);
  assign wr_pc1     = wr & (idx == msc_pkg::IDX_PC1);
  assign path_start = wr_ucr & wdat[msc_pkg::UCR_PATH];

  // Each strobe is high for exactly the cycle after the write.
  always_ff @(posedge clk_i) begin
    if (srst) begin
      slv_q   <= 1'b0;
      mprst_q <= 1'b0;
      ffrst_q <= 1'b0;
    end else begin
      slv_q   <= wr_ucr & wdat[msc_pkg::UCR_SLV];
      mprst_q <= wr_ucr & wdat[msc_pkg::UCR_MP_RST];
      ffrst_q <= wr_ucr & wdat[msc_pkg::UCR_FF_RST];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      devrst_q <= 1'b0;
    end else begin
      devrst_q <= wr_pc1 & wdat[msc_pkg::PC1_DEVRST];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mp_reset_o     <= 1'b0;
      fifo_reset_o   <= 1'b0;
      slave_reset_o  <= 1'b0;
      device_reset_o <= 1'b0;
    end else begin
      mp_reset_o     <= wr_ucr & wdat[msc_pkg::UCR_MP_RST];
      fifo_reset_o   <= wr_ucr & wdat[msc_pkg::UCR_FF_RST];
      slave_reset_o  <= wr_ucr & wdat[msc_pkg::UCR_SLV];
      device_reset_o <= wr_pc1 & wdat[msc_pkg::PC1_DEVRST];
    end
  end

  // The 8 MHz period is not a whole number of cycles; the pulse is cut to 31.
  msc_pulse #(
    .LEN (msc_pkg::PATH_RST_CYCLES)
  ) u_path_pulse (
    .clk_i   (clk_i),
    .rst_i   (srst),
    .start_i (path_start),
    .pulse_o (path_reset_o)
  );

  // ----------------------------------------
  // Motion processor run control
  // ----------------------------------------
  msc_pkg::msc_mp_state_t mp_state_q;
  logic                   sensors_off;

  always_ff @(posedge clk_i) begin
    if (srst | mprst_q) begin
      mp_state_q <= msc_pkg::MSC_MP_OFF;
    end else begin
      case (mp_state_q)
        msc_pkg::MSC_MP_OFF:   if (ucr_q[msc_pkg::UCR_MP_EN]) begin
          mp_state_q <= msc_pkg::MSC_MP_RUN;
        end
        msc_pkg::MSC_MP_RUN:   if (!ucr_q[msc_pkg::UCR_MP_EN]) begin
          mp_state_q <= msc_pkg::MSC_MP_DRAIN;
        end
        msc_pkg::MSC_MP_DRAIN: if (ucr_q[msc_pkg::UCR_MP_EN]) begin
          mp_state_q <= msc_pkg::MSC_MP_RUN;
        end else if (mp_done_i) begin
          mp_state_q <= msc_pkg::MSC_MP_OFF;
        end
        default:               mp_state_q <= msc_pkg::MSC_MP_OFF;
      endcase
    end
  end

  assign sensors_off = &apc_q[5:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mp_run_o           <= 1'b0;
      fifo_host_access_o <= 1'b0;
    end else begin
      mp_run_o           <= (mp_state_q != msc_pkg::MSC_MP_OFF) & ~(sensors_off & rate_8khz_i);
      fifo_host_access_o <= ucr_q[msc_pkg::UCR_FIFO];
    end
  end

  // ----------------------------------------
  // Power management and duty cycling
  // ----------------------------------------
  localparam int BW = $clog2(WAKE_BASE_CYCLES + 1);

  logic          cyc_active;
  logic          accel_all_off;
  logic          tick;
  logic [BW-1:0] base_q;
  logic [7:0]    div_q;

  assign cyc_active    = pc1_q[msc_pkg::PC1_CYCLE] & ~pc1_q[msc_pkg::PC1_SLEEP] & ~pc1_q[msc_pkg::PC1_STBY];
  assign accel_all_off = apc_q[msc_pkg::APC_XA] & apc_q[msc_pkg::APC_YA] & apc_q[msc_pkg::APC_ZA];
  assign tick          = (base_q == BW'(WAKE_BASE_CYCLES - 1)) & (div_q == srd_q);

  // Wake period is (divider + 1) base intervals.
  always_ff @(posedge clk_i) begin
    if (srst | ~cyc_active) begin
      base_q <= '0;
      div_q  <= 8'h00;
    end else if (base_q == BW'(WAKE_BASE_CYCLES - 1)) begin
      base_q <= '0;
      div_q  <= (div_q == srd_q) ? 8'h00 : div_q + 8'h01;
    end else begin
      base_q <= base_q + BW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accel_wake_o    <= 1'b0;
      accel_sample_o  <= 1'b0;
      sleep_o         <= 1'b1;
      gyro_drive_en_o <= 1'b0;
      pll_en_o        <= 1'b0;
      gyro_sense_en_o <= 1'b0;
    end else begin
      accel_wake_o    <= cyc_active & tick;
      accel_sample_o  <= cyc_active & tick & ~accel_all_off;
      sleep_o         <= pc1_q[msc_pkg::PC1_SLEEP];
      gyro_drive_en_o <= ~pc1_q[msc_pkg::PC1_SLEEP];
      pll_en_o        <= ~pc1_q[msc_pkg::PC1_SLEEP];
      gyro_sense_en_o <= ~pc1_q[msc_pkg::PC1_SLEEP] & ~pc1_q[msc_pkg::PC1_STBY];
    end
  end

  // ----------------------------------------
  // Wake-on-motion comparison
  // ----------------------------------------
  logic        wom_en;
  logic        have_ref_q;
  logic [15:0] ref_x_q;
  logic [15:0] ref_y_q;
  logic [15:0] ref_z_q;
  logic [2:0]  hits;
  logic        wst_clr;

  assign wom_en  = mwc_q[msc_pkg::MWC_EN];
  assign hits[2] = wom_en & have_ref_q & accel_valid_i & hit(abs_diff(accel_x_i, ref_x_q), thr_q);
  assign hits[1] = wom_en & have_ref_q & accel_valid_i & hit(abs_diff(accel_y_i, ref_y_q), thr_q);
  assign hits[0] = wom_en & have_ref_q & accel_valid_i & hit(abs_diff(accel_z_i, ref_z_q), thr_q);
  assign wst_clr = rd & (idx == msc_pkg::IDX_WST);

  always_ff @(posedge clk_i) begin
    if (srst | ~wom_en | path_reset_o) begin
      have_ref_q <= 1'b0;
      ref_x_q    <= 16'h0000;
      ref_y_q    <= 16'h0000;
      ref_z_q    <= 16'h0000;
    end else if (accel_valid_i & (~have_ref_q | mwc_q[msc_pkg::MWC_MODE])) begin
      have_ref_q <= 1'b1;
      ref_x_q    <= accel_x_i;
      ref_y_q    <= accel_y_i;
      ref_z_q    <= accel_z_i;
    end
  end

  // Flags clear on read; a hit in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (srst) begin
      wst_q <= 8'h00;
    end else begin
      wst_q[msc_pkg::WST_X] <= hits[2] | (wst_q[msc_pkg::WST_X] & ~wst_clr);
      wst_q[msc_pkg::WST_Y] <= hits[1] | (wst_q[msc_pkg::WST_Y] & ~wst_clr);
      wst_q[msc_pkg::WST_Z] <= hits[0] | (wst_q[msc_pkg::WST_Z] & ~wst_clr);
    end
  end

  assign wake_flags_o = wst_q[7:5];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [7:0] plen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i | ~path_reset_o) begin
      plen_q <= 8'h00;
    end else begin
      plen_q <= plen_q + 8'h01;
    end
  end

  property p_mp_rst_one;
    @(posedge clk_i) disable iff (rst_i) mp_reset_o |=> !mp_reset_o;
  endproperty
  a_mp_rst_one: assert property (p_mp_rst_one) else $error("processor reset longer than one cycle");

  property p_ff_rst_one;
    @(posedge clk_i) disable iff (rst_i) $rose(fifo_reset_o) |=> !fifo_reset_o && !ffrst_q;
  endproperty
  a_ff_rst_one: assert property (p_ff_rst_one) else $error("fifo reset did not self clear");

  property p_path_len;
    @(posedge clk_i) disable iff (rst_i) $fell(path_reset_o) |-> $past(plen_q) == 8'(msc_pkg::PATH_RST_CYCLES - 1);
  endproperty
  a_path_len: assert property (p_path_len) else $error("path reset pulse length wrong");

  property p_path_start;
    @(posedge clk_i) disable iff (srst) path_start |=> path_reset_o;
  endproperty
  a_path_start: assert property (p_path_start) else $error("path reset did not start");

  property p_sleep_boot;
    @(posedge clk_i) $fell(rst_i) |-> sleep_o ##1 sleep_o;
  endproperty
  a_sleep_boot: assert property (p_sleep_boot) else $error("chip not asleep after reset");

  property p_standby;
    @(posedge clk_i) disable iff (srst)
      (pc1_q[msc_pkg::PC1_STBY] && !pc1_q[msc_pkg::PC1_SLEEP]) |=> gyro_drive_en_o && pll_en_o && !gyro_sense_en_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby power state wrong");

  property p_no_sample;
    @(posedge clk_i) disable iff (srst) (cyc_active && tick && accel_all_off) |=> accel_wake_o && !accel_sample_o;
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("sample taken with all axes off");

  property p_freeze;
    @(posedge clk_i) disable iff (srst | mprst_q)
      (mp_state_q == msc_pkg::MSC_MP_DRAIN && !ucr_q[msc_pkg::UCR_MP_EN] && mp_done_i) |=> ##1 !mp_run_o;
  endproperty
  a_freeze: assert property (p_freeze) else $error("processor did not freeze after done");

  property p_flag_x;
    @(posedge clk_i) disable iff (srst) hits[2] |=> wake_flags_o[2];
  endproperty
  a_flag_x: assert property (p_flag_x) else $error("x wake flag not raised");

  property p_fifo_access;
    @(posedge clk_i) disable iff (rst_i) !ucr_q[msc_pkg::UCR_FIFO] ##1 !ucr_q[msc_pkg::UCR_FIFO] |-> !fifo_host_access_o;
  endproperty
  a_fifo_access: assert property (p_fifo_access) else $error("fifo access not blocked");

endmodule : msc_regs

`default_nettype wire

// File: verif/tb_motion_sensor_control_regs.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", nm, (e), (g)); end end

module tb_motion_sensor_control_regs;

  // ----------------------------------------
  // Stimulus, responses and the device
  // ----------------------------------------
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [9:0]  wb_adr  = 10'h000;
  logic [3:0]  wb_sel  = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic        acc_v   = 1'b0;
  logic [15:0] ax      = 16'h0;
  logic [15:0] ay      = 16'h0;
  logic [15:0] az      = 16'h0;
  logic        mp_done = 1'b0;
  logic        rate8   = 1'b0;
  logic [31:0] wb_rdat;
  logic        wb_ack, mp_run, mp_rst, fifo_acc, fifo_rst, slv_rst, path_rst, dev_rst;
  logic        sleep, gdrv, pll, gsense, wake, samp;
  logic [2:0]  flags;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cyc_cnt      = 0;
  int          seed, thr, refv [3];
  bit          wmode, haveref;
  logic [2:0]  mflg;

  always #2 clk_i = ~clk_i;

  msc_regs #(.AW(10), .WAKE_BASE_CYCLES(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .accel_valid_i(acc_v), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az), .mp_done_i(mp_done),
    .rate_8khz_i(rate8), .mp_run_o(mp_run), .mp_reset_o(mp_rst), .fifo_host_access_o(fifo_acc),
    .fifo_reset_o(fifo_rst), .slave_reset_o(slv_rst), .path_reset_o(path_rst),
    .device_reset_o(dev_rst), .sleep_o(sleep), .gyro_drive_en_o(gdrv), .pll_en_o(pll),
    .gyro_sense_en_o(gsense), .accel_wake_o(wake), .accel_sample_o(samp), .wake_flags_o(flags)
  );

  // ----------------------------------------
  // Bus cycles, samples and the wake model
  // ----------------------------------------
  // The master waits for ack as long as it takes; only the bench timeout ends a hang.
  task automatic wb_io(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= s;
    wb_wdat <= {24'hA5A5A5, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_io

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb_io(1'b1, idx, d, 4'hF, q);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    logic [31:0] q;
    wb_io(1'b0, idx, 8'h00, 4'hF, q);
    `CHK(nm, {24'h0, e}, q)
  endtask : rdc

  // The first sample after enable only seeds the reference.
  function automatic void wom_model(input int s [3]);
    for (int i = 0; i < 3; i++) begin
      if (haveref && (s[i] - refv[i] > thr || refv[i] - s[i] > thr)) mflg[2-i] = 1'b1;
      if (!haveref || wmode) refv[i] = s[i];
    end
    haveref = 1'b1;
  endfunction : wom_model

  task automatic smp(input int s [3], input bit en);
    @(posedge clk_i);
    acc_v <= 1'b1;
    ax    <= 16'(s[0]);
    ay    <= 16'(s[1]);
    az    <= 16'(s[2]);
    @(posedge clk_i);
    acc_v <= 1'b0;
    if (en) wom_model(s);
  endtask : smp

  task automatic cnt(input int w, output int nw, output int ns);
    nw = 0;
    ns = 0;
    repeat (w) begin
      @(posedge clk_i);
      nw += (wake === 1'b1) ? 1 : 0;
      ns += (samp === 1'b1) ? 1 : 0;
    end
  endtask : cnt

  function automatic logic pv(input int b);
    case (b)
      3: return mp_rst;
      2: return fifo_rst;
      default: return slv_rst;
    endcase
  endfunction : pv

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Hangs are cut short well beyond the fewer than two thousand cycles the tests need.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin : main
    int s [3];
    int nw, ns, per;
    static int pb [3] = '{3, 2, 4};
    logic [7:0] d;
    logic [31:0] dq;
    static logic [7:0] apcv [4] = '{8'h00, 8'h38, 8'h00, 8'h00};
    static logic [7:0] pcv [4] = '{8'h20, 8'h20, 8'h60, 8'h30};
    static int ewk [4] = '{8, 8, 0, 0};
    static int esm [4] = '{8, 0, 0, 0};
    seed = $urandom(71806);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(msc_pkg::IDX_PC1, 8'h40, "power ctrl reset");
    `CHK("sleep after reset", 1'b1, sleep)
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(msc_pkg::IDX_MWC, d);
      rdc(msc_pkg::IDX_MWC, d & 8'hC0, "wake ctrl");
      wr(msc_pkg::IDX_UCR, d & 8'h62);
      rdc(msc_pkg::IDX_UCR, d & 8'h40, "user ctrl");
      wr(msc_pkg::IDX_PC1, d & 8'h7F);
      rdc(msc_pkg::IDX_PC1, d & 8'h70, "power ctrl");
    end
    wr(msc_pkg::IDX_MWC, 8'h00);
    wb_io(1'b1, msc_pkg::IDX_MWC, 8'hC0, 4'hE, dq);
    rdc(msc_pkg::IDX_MWC, 8'h00, "masked write");
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'h00, "unmapped");
    $display("Test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(msc_pkg::IDX_PC1, {1'b0, i[1], 1'b0, i[0], 4'h0});
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("power outputs", {i[1], !i[1], !i[1], !i[1] && !i[0]}, {sleep, gdrv, pll, gsense})
    end
    wr(msc_pkg::IDX_UCR, 8'h40);
    @(posedge clk_i);
    #1;
    `CHK("fifo access on", 1'b1, fifo_acc)
    foreach (pb[i]) begin
      wr(msc_pkg::IDX_UCR, 8'(1 << pb[i]));
      #1;
      `CHK("reset strobe", 1'b1, pv(pb[i]))
      @(posedge clk_i);
      #1;
      `CHK("reset strobe end", 1'b0, pv(pb[i]))
      `CHK("fifo access off", 1'b0, fifo_acc)
      rdc(msc_pkg::IDX_UCR, 8'h00, "strobe bits");
    end
    wr(msc_pkg::IDX_UCR, 8'h01);
    #1;
    nw = 0;
    while (path_rst === 1'b1 && nw < 100) begin
      nw++;
      @(posedge clk_i);
      #1;
    end
    `CHK("path pulse length", msc_pkg::PATH_RST_CYCLES, nw)
    rdc(msc_pkg::IDX_UCR, 8'h00, "path bit");
    $display("Test strobes done");
    d = 8'($urandom_range(3));
    per = (int'(d) + 1) * 8;
    wr(msc_pkg::IDX_SRD, d);
    for (int i = 0; i < 4; i++) begin
      wr(msc_pkg::IDX_APC, apcv[i]);
      wr(msc_pkg::IDX_PC1, pcv[i]);
      cnt(per + 4, nw, ns);
      cnt(8 * per, nw, ns);
      `CHK("wake count", ewk[i], nw)
      `CHK("sample count", esm[i], ns)
    end
    wr(msc_pkg::IDX_APC, 8'h00);
    wr(msc_pkg::IDX_PC1, 8'h00);
    $display("Test duty cycle done");
    for (int k = 0; k < 3; k++) begin
      s = '{200 * k, -90 * k, 60 * k};
      smp(s, 1'b0);
      #1;
      `CHK("flags while off", 3'b000, flags)
    end
    for (int m = 0; m < 2; m++) begin
      wr(msc_pkg::IDX_MWC, 8'h00);
      wr(msc_pkg::IDX_WST, 8'h00);
      rdc(msc_pkg::IDX_WST, 8'h00, "status idle");
      mflg = 3'b000;
      haveref = 1'b0;
      wmode = m[0];
      thr = 8 + $urandom_range(20);
      wr(msc_pkg::IDX_THR, 8'(thr));
      wr(msc_pkg::IDX_MWC, {1'b1, m[0], 6'h3F});
      for (int k = 0; k < 12; k++) begin
        if (k == 0) s = '{0, 0, 0};
        else if (k == 1) s = '{thr, -thr, 0};
        else if (k == 2) s = '{thr + 1, 0, 0};
        else s = '{$urandom_range(80) - 40, $urandom_range(80) - 40, $urandom_range(80) - 40};
        smp(s, 1'b1);
        #1;
        `CHK("wake flags", mflg, flags)
      end
      rdc(msc_pkg::IDX_WST, {mflg, 5'h00}, "wake status");
      #1;
      `CHK("flags after read", 3'b000, flags)
    end
    $display("Test wake on motion done");
    wr(msc_pkg::IDX_UCR, 8'h80);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("processor runs", 1'b1, mp_run)
    wr(msc_pkg::IDX_APC, 8'h3F);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("runs sensors off", 1'b1, mp_run)
    @(posedge clk_i);
    rate8 <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("stops at 8 kHz", 1'b0, mp_run)
    @(posedge clk_i);
    rate8 <= 1'b0;
    // Host stops internal FIFO writes by turning the processor off.
    wr(msc_pkg::IDX_APC, 8'h00);
    wr(msc_pkg::IDX_UCR, 8'h00);
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("runs until done", 1'b1, mp_run)
    @(posedge clk_i);
    mp_done <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("frozen after done", 1'b0, mp_run)
    @(posedge clk_i);
    mp_done <= 1'b0;
    $display("Test processor done");
    wr(msc_pkg::IDX_MWC, 8'hC0);
    wr(msc_pkg::IDX_PC1, 8'h80);
    #1;
    `CHK("device reset strobe", 1'b1, dev_rst)
    repeat (2) @(posedge clk_i);
    rdc(msc_pkg::IDX_MWC, 8'h00, "wake ctrl default");
    rdc(msc_pkg::IDX_PC1, 8'h40, "power ctrl default");
    $display("Test full reset done");
    test_done();
  end

endmodule : tb_motion_sensor_control_regs

`undef CHK
`default_nettype wire
